// ==== bench/pack_current_monitor_tb.sv ====
// Testbench of the pack current monitor: register tasks, threshold sweeps,
// delay, direction and mode scenarios. Assumes pcm_pkg and the sense model.
`timescale 1ns/10ps
module pack_current_monitor_tb import pcm_pkg::*; ;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr = '0;
    logic [31:0] regWdata = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [2:0] powerMode = 3'h0;
    logic signed [16:0] senseCmd = '0;
    logic convReq = 1'b0;
    logic [13:0] convCode = '0;
    logic [13:0] nvCalOffset = 14'h0100;
    logic [31:0] regRdata;
    logic signed [16:0] ocSense;
    logic [13:0] adcRaw;
    logic adcValid, fetsOn, docFlag, cocFlag, scFlag, loadPr, chgrPr, chgDir, dsgDir;
    logic [1:0] measGain, ocGain;
    int failCount = 0;
    int checkCount = 0;
    int docMv[8] = '{4, 8, 16, 24, 32, 48, 64, 96};
    int cocMv[8] = '{1, 2, 4, 6, 8, 12, 16, 24};
    int scMv[8] = '{16, 24, 32, 48, 64, 96, 128, 256};
    int gainSense[3] = '{20, 200, -200};
    logic [2:0] modes[5] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6};

    pcm_sense_model model_u (.clk_sys(clk_sys), .reset_n(reset_n), .senseCmd(senseCmd), .convReq(convReq),
        .convCode(convCode), .ocSense_ff(ocSense), .adcRaw_ff(adcRaw), .adcValid_ff(adcValid));
    // Short direction filter keeps the run brief
    pcm_current_monitor #(.DIR_FILT_CYC(20)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata_ff(regRdata),
        .powerMode(powerMode), .ocSense(ocSense), .adcRaw(adcRaw), .adcValid(adcValid),
        .nvCalOffset(nvCalOffset), .measGain_ff(measGain), .ocGain_ff(ocGain), .fetsOn_ff(fetsOn),
        .dischgOcFlag_ff(docFlag), .chgOcFlag_ff(cocFlag), .shortFlag_ff(scFlag), .loadPresent_ff(loadPr),
        .chargerPresent_ff(chgrPr), .chgDir_ff(chgDir), .dischgDir_ff(dsgDir));

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        #1;
        checkCount++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr

    task automatic chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        cmp(regRdata & mask, exp);
    endtask : chk

    task automatic sense(input int v);
        @(posedge clk_sys);
        senseCmd <= 17'(v);
    endtask : sense

    // Level equal to a threshold must not trip; one step above must
    task automatic sweep(input int shift, input int tbl[8], input int sgn, input logic [31:0] base,
                         input logic [31:0] mask, input logic [31:0] exp);
        for (int i = 0; i < 8; i++) begin
            wr(REG_CFG, base | (32'(i) << shift));
            sense(sgn * tbl[i] * 8);
            cyc(4);
            chk(REG_STATUS, 32'h0000_001F, 32'h0000_0000);
            sense(sgn * (tbl[i] * 8 + 1));
            cyc(4);
            chk(REG_STATUS, mask, exp);
            cmp(32'({fetsOn, dsgDir, chgDir, chgrPr, loadPr, scFlag, cocFlag, docFlag}) & mask, exp);
            sense(0);
            wr(REG_STATUS, 32'h0000_001F);
            chk(REG_STATUS, 32'h0000_001F, 32'h0000_0000);
        end
    endtask : sweep

    task automatic finalReport;
        $display("Checks %0d, mismatches %0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finalReport

    initial begin
        #(95000 * 25);
        failCount++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        finalReport();
    end

    initial begin
        cyc(4);
        reset_n <= 1'b1;
        chk(REG_CFG, '1, 32'h0000_0000);
        chk(REG_DLY_DOC, '1, 32'h0000_040A);
        chk(REG_DLY_COC, '1, 32'h0000_040A);
        chk(REG_DLY_SC, '1, 32'h0000_00C8);
        chk(REG_STATUS, '1, 32'h0000_0180);
        wr(8'h18, '1);
        chk(8'h18, '1, 32'h0000_0000);
        for (int g = 0; g < 4; g++) begin
            wr(REG_CFG, 32'(g));
            cyc(2);
            cmp(32'(measGain), (g == 3) ? 32'h0000_0002 : 32'(g));
            cmp(32'(ocGain), 32'h0000_0002);
        end
        for (int k = 0; k < 3; k++) begin
            sense(gainSense[k]);
            cyc(4);
            cmp(32'(ocGain), (k == 0) ? 32'h0000_0001 : 32'h0000_0000);
        end
        sense(0);
        @(posedge clk_sys);
        convReq <= 1'b1;
        convCode <= 14'h1000;
        @(posedge clk_sys);
        convReq <= 1'b0;
        cyc(2);
        chk(REG_CURRENT, '1, 32'h03C0_0F00);
        wr(REG_CURRENT, '1);
        chk(REG_CURRENT, '1, 32'h03C0_0F00);
        @(posedge clk_sys);
        nvCalOffset <= 14'h0040;
        convReq <= 1'b1;
        @(posedge clk_sys);
        convReq <= 1'b0;
        cyc(2);
        chk(REG_CURRENT, '1, 32'h03F0_0FC0);
        wr(REG_DLY_COC, 32'h0000_0000);
        wr(REG_DLY_DOC, 32'h0000_0000);
        wr(REG_DLY_SC, 32'h0000_0000);
        sweep(5, cocMv, -1, 32'h0000_0F1C, 32'h0000_0093, 32'h0000_0092);
        sweep(2, docMv, 1, 32'h0000_07E0, 32'h0000_0089, 32'h0000_0009);
        wr(REG_DLY_DOC, 32'h0000_0FFF);
        sweep(8, scMv, 1, 32'h0000_08FC, 32'h0000_008F, 32'h0000_000C);
        // A one-cycle dip must throw away the first 150 cycles
        wr(REG_DLY_DOC, 32'h0000_0005);
        wr(REG_CFG, 32'h0000_07E0);
        sense(40);
        cyc(150);
        sense(0);
        sense(40);
        cyc(150);
        chk(REG_STATUS, 32'h0000_0001, 32'h0000_0000);
        cyc(60);
        chk(REG_STATUS, 32'h0000_0001, 32'h0000_0001);
        sense(0);
        wr(REG_STATUS, 32'h0000_001F);
        wr(REG_DLY_DOC, 32'h0000_0402);
        sense(40);
        cyc(39000);
        chk(REG_STATUS, 32'h0000_0001, 32'h0000_0000);
        cyc(41100);
        chk(REG_STATUS, 32'h0000_0001, 32'h0000_0001);
        sense(0);
        wr(REG_STATUS, 32'h0000_001F);
        cyc(30);
        sense(3);
        cyc(15);
        chk(REG_STATUS, 32'h0000_0060, 32'h0000_0000);
        cyc(12);
        chk(REG_STATUS, 32'h0000_0060, 32'h0000_0040);
        cmp(32'({dsgDir, chgDir}), 32'h0000_0002);
        sense(0);
        cyc(15);
        sense(3);
        sense(0);
        cyc(15);
        chk(REG_STATUS, 32'h0000_0060, 32'h0000_0040);
        cyc(12);
        chk(REG_STATUS, 32'h0000_0060, 32'h0000_0000);
        sense(-3);
        cyc(27);
        chk(REG_STATUS, 32'h0000_0060, 32'h0000_0020);
        cmp(32'({dsgDir, chgDir}), 32'h0000_0001);
        sense(0);
        wr(REG_DLY_DOC, 32'h0000_0000);
        cyc(30);
        for (int m = 0; m < 5; m++) begin
            powerMode <= modes[m];
            sense(40);
            cyc(4);
            chk(REG_STATUS, 32'h0000_0161, (m < 3) ? 32'h0000_0101 : 32'h0000_0000);
            sense(0);
            wr(REG_STATUS, 32'h0000_001F);
        end
        powerMode <= 3'h0;
        cyc(2);
        finalReport();
    end
endmodule : pack_current_monitor_tb

// ==== bench/pcm_sense_model.sv ====
// Far-side model: sense resistor voltage seen by the detector path and the
// measurement converter. Assumes the bench commands levels on clk_sys.
`timescale 1ns/10ps
module pcm_sense_model (
    input wire logic clk_sys, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic signed [16:0] senseCmd, // Commanded sense level, 1/8 mV
    input wire logic convReq, // Start one conversion
    input wire logic [13:0] convCode, // Code that conversion returns
    output logic signed [16:0] ocSense_ff, // Sense seen by detectors
    output logic [13:0] adcRaw_ff, // Conversion result
    output logic adcValid_ff // Conversion done pulse
);
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ocSense_ff <= '0;
            adcValid_ff <= 1'b0;
            adcRaw_ff <= '0;
        end else begin
            ocSense_ff <= senseCmd;
            adcValid_ff <= convReq;
            // Stale result flips so nothing can lean on it outside the pulse
            adcRaw_ff <= convReq ? convCode : ~adcRaw_ff;
        end
    end
endmodule : pcm_sense_model

// ==== core/pcm_current_monitor.sv ====
// Pack current monitor: measurement result, direction filter, three delayed
// overcurrent detectors and power FET shutdown request.
// Assumes sense samples and mode arrive from logic on clk_sys.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module pcm_current_monitor
    import pcm_pkg::*;
#(
    parameter int DIR_FILT_CYC = DIR_FILT_CYCLES
) (
    input wire logic clk_sys, // 40 MHz system clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [7:0] regAddr, // Register byte address
    input wire logic [31:0] regWdata, // Write data
    input wire logic regWrite, // Write strobe
    input wire logic regRead, // Read strobe
    output logic [31:0] regRdata_ff, // Read data, cycle after strobe
    input wire logic [2:0] powerMode, // Operating mode
    input wire logic signed [16:0] ocSense, // Overcurrent path sense, 1/8 mV
    input wire logic [13:0] adcRaw, // Measurement conversion result
    input wire logic adcValid, // Conversion done pulse
    input wire logic [13:0] nvCalOffset, // Factory offset from nonvolatile store
    output logic [1:0] measGain_ff, // Measurement amplifier gain
    output logic [1:0] ocGain_ff, // Overcurrent amplifier gain
    output logic fetsOn_ff, // Power FETs allowed on
    output logic dischgOcFlag_ff, // Discharge overcurrent
    output logic chgOcFlag_ff, // Charge overcurrent
    output logic shortFlag_ff, // Discharge short-circuit
    output logic loadPresent_ff, // Load present
    output logic chargerPresent_ff, // Charger present
    output logic chgDir_ff, // Charge current present
    output logic dischgDir_ff // Discharge current present
);

    localparam int DFW = $clog2(DIR_FILT_CYC + 2);

    logic [11:0] cfg_ff;
    logic [11:0] dly_ff [3];
    logic [13:0] result_ff;
    logic [11:0] cmpValue_ff;
    logic monitorOn;
    logic hostFetCtl;
    logic [2:0] exceed;
    logic [2:0] trip;
    logic [9:0] dlyCnt_ff [3];
    logic usTick, msTick, sTick, minTick;
    logic [5:0] usCnt_ff;
    logic [9:0] msCnt_ff;
    logic [9:0] sCnt_ff;
    logic [5:0] minCnt_ff;
    logic isChg, isDsg;
    logic [DFW-1:0] chgFilt_ff;
    logic [DFW-1:0] dsgFilt_ff;
    logic signed [16:0] thr [3];
    logic signed [16:0] absSense;
    logic [8:0] stClear;
    logic [31:0] nxt_rdata;

    // Current monitor is off in sleep and power-down
    assign monitorOn = (powerMode != PCM_MODE_SLEEP) && (powerMode != PCM_MODE_POWERDOWN); // RULE_01
    assign hostFetCtl = cfg_ff[CFG_HOSTFET_BIT];

    // Register writes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_ff <= CFG_RESET;
            dly_ff[DET_DOC] <= DLY_DOC_RESET;
            dly_ff[DET_COC] <= DLY_COC_RESET;
            dly_ff[DET_SC] <= DLY_SC_RESET;
        end else if (regWrite) begin
            case (regAddr)
                REG_CFG: cfg_ff <= regWdata[11:0];
                REG_DLY_DOC: dly_ff[DET_DOC] <= regWdata[11:0]; // RULE_15
                REG_DLY_COC: dly_ff[DET_COC] <= regWdata[11:0];
                REG_DLY_SC: dly_ff[DET_SC] <= regWdata[11:0];
                default: ;
            endcase
        end
    end

    // Write-one-to-clear on status fault bits
    assign stClear = (regWrite && regAddr == REG_STATUS) ? regWdata[8:0] : 9'h0_00;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (regAddr)
            REG_CFG: nxt_rdata = {20'h0_0000, cfg_ff};
            REG_DLY_DOC: nxt_rdata = {20'h0_0000, dly_ff[DET_DOC]};
            REG_DLY_COC: nxt_rdata = {20'h0_0000, dly_ff[DET_COC]};
            REG_DLY_SC: nxt_rdata = {20'h0_0000, dly_ff[DET_SC]};
            REG_STATUS: nxt_rdata = {23'h00_0000, monitorOn, fetsOn_ff, dischgDir_ff, chgDir_ff,
                                     chargerPresent_ff, loadPresent_ff, shortFlag_ff,
                                     chgOcFlag_ff, dischgOcFlag_ff};
            REG_CURRENT: nxt_rdata = {4'h0, cmpValue_ff, 2'b00, result_ff};
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            regRdata_ff <= 32'h0000_0000;
        end else if (regRead) begin
            regRdata_ff <= nxt_rdata;
        end else begin
            regRdata_ff <= 32'h0000_0000;
        end
    end

    // Measurement gain; code 11 falls back to x500, the finest range
    // Full scale is 250mV at x5, 25mV at x50, 2.5mV at x500
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            measGain_ff <= PCM_GAIN_X5;
        end else if (cfg_ff[CFG_GAIN_LSB +: 2] == 2'b11) begin
            measGain_ff <= PCM_GAIN_X500; // RULE_06 RULE_07
        end else begin
            measGain_ff <= cfg_ff[CFG_GAIN_LSB +: 2]; // RULE_06
        end
    end

    // Offset-corrected result and compare value
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            result_ff <= 14'h0000;
            cmpValue_ff <= 12'h000;
        end else if (adcValid && monitorOn) begin
            result_ff <= adcRaw - nvCalOffset; // RULE_08 RULE_09
            cmpValue_ff <= 12'(14'(adcRaw - nvCalOffset) >> 2); // RULE_08
        end
    end

    // Overcurrent path gain follows the signal level, not the measurement gain
    assign absSense = ocSense[16] ? -ocSense : ocSense;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ocGain_ff <= PCM_GAIN_X5;
        end else if (absSense >= AUTO_X5_LEVEL) begin
            ocGain_ff <= PCM_GAIN_X5; // RULE_10
        end else if (absSense >= AUTO_X50_LEVEL) begin
            ocGain_ff <= PCM_GAIN_X50;
        end else begin
            ocGain_ff <= PCM_GAIN_X500;
        end
    end

    // Threshold lookup, in sense units
    assign thr[DET_DOC] = 17'(DOC_THR_MV[cfg_ff[CFG_DOC_LSB +: 3]] * SENSE_LSB_PER_MV); // RULE_11
    assign thr[DET_COC] = 17'(COC_THR_MV[cfg_ff[CFG_COC_LSB +: 3]] * SENSE_LSB_PER_MV); // RULE_12
    assign thr[DET_SC] = 17'(SC_THR_MV[cfg_ff[CFG_SC_LSB +: 3]] * SENSE_LSB_PER_MV); // RULE_13

    assign exceed[DET_DOC] = monitorOn && (ocSense > thr[DET_DOC]); // RULE_02
    assign exceed[DET_COC] = monitorOn && (ocSense < -thr[DET_COC]); // RULE_02
    assign exceed[DET_SC] = monitorOn && (ocSense > thr[DET_SC]); // RULE_02

    // Time base: us, ms, s, minute enables
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            usCnt_ff <= 6'h00;
            msCnt_ff <= 10'h000;
            sCnt_ff <= 10'h000;
            minCnt_ff <= 6'h00;
        end else begin
            usCnt_ff <= usTick ? 6'h00 : usCnt_ff + 6'h01;
            if (usTick) begin
                msCnt_ff <= msTick ? 10'h000 : msCnt_ff + 10'h001;
            end
            if (msTick) begin
                sCnt_ff <= sTick ? 10'h000 : sCnt_ff + 10'h001;
            end
            if (sTick) begin
                minCnt_ff <= minTick ? 6'h00 : minCnt_ff + 6'h01;
            end
        end
    end

    assign usTick = usCnt_ff == 6'(US_TICK_CYCLES - 1);
    assign msTick = usTick && (msCnt_ff == 10'(US_PER_MS - 1));
    assign sTick = msTick && (sCnt_ff == 10'(MS_PER_S - 1));
    assign minTick = sTick && (minCnt_ff == 6'(S_PER_MIN - 1));

    // Delay timers: first unit may be partial, so real delay is up to one unit short
    for (genvar k = 0; k < 3; k++) begin : g_det
        logic tick;
        always_comb begin
            case (dly_ff[k][DLY_SCALE_LSB +: 2]) // RULE_16
                2'b00: tick = usTick;
                2'b01: tick = msTick;
                2'b10: tick = sTick;
                default: tick = minTick;
            endcase
        end
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                dlyCnt_ff[k] <= 10'h000;
            end else if (!exceed[k]) begin
                dlyCnt_ff[k] <= 10'h000; // RULE_17
            end else if (tick && dlyCnt_ff[k] != 10'h3FF) begin
                dlyCnt_ff[k] <= dlyCnt_ff[k] + 10'h001;
            end
        end
        assign trip[k] = exceed[k] && (dlyCnt_ff[k] >= dly_ff[k][9:0]); // RULE_14
    end

    // Fault flags; a new trip wins over a software clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dischgOcFlag_ff <= 1'b0;
            chgOcFlag_ff <= 1'b0;
            shortFlag_ff <= 1'b0;
            loadPresent_ff <= 1'b0;
            chargerPresent_ff <= 1'b0;
        end else begin
            dischgOcFlag_ff <= trip[DET_DOC] | (dischgOcFlag_ff & ~stClear[ST_DOC]); // RULE_18
            chgOcFlag_ff <= trip[DET_COC] | (chgOcFlag_ff & ~stClear[ST_COC]); // RULE_19
            shortFlag_ff <= trip[DET_SC] | (shortFlag_ff & ~stClear[ST_SC]); // RULE_21
            loadPresent_ff <= trip[DET_DOC] | trip[DET_SC] | (loadPresent_ff & ~stClear[ST_LOAD]); // RULE_18
            chargerPresent_ff <= trip[DET_COC] | (chargerPresent_ff & ~stClear[ST_CHGR]); // RULE_19
        end
    end

    // FET drive; host keeps ownership on overcurrent but never on short-circuit
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fetsOn_ff <= 1'b1;
        end else begin
            fetsOn_ff <= !(shortFlag_ff | (!hostFetCtl & (dischgOcFlag_ff | chgOcFlag_ff))); // RULE_20 RULE_21
        end
    end

    // Direction filter
    assign isChg = monitorOn && (ocSense < -DIR_DET_LEVEL); // RULE_03
    assign isDsg = monitorOn && (ocSense > DIR_DET_LEVEL); // RULE_03

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            chgFilt_ff <= '0;
            dsgFilt_ff <= '0;
            chgDir_ff <= 1'b0;
            dischgDir_ff <= 1'b0;
        end else begin
            // Counter restarts whenever the input agrees with the held flag
            if ((isDsg == dischgDir_ff) || dsgFilt_ff == DFW'(DIR_FILT_CYC)) begin
                dsgFilt_ff <= '0;
            end else begin
                dsgFilt_ff <= dsgFilt_ff + DFW'(1);
            end
            if ((isChg == chgDir_ff) || chgFilt_ff == DFW'(DIR_FILT_CYC)) begin
                chgFilt_ff <= '0;
            end else begin
                chgFilt_ff <= chgFilt_ff + DFW'(1);
            end
            if (!monitorOn) begin
                dischgDir_ff <= 1'b0;
                chgDir_ff <= 1'b0;
            end else begin
                if (dsgFilt_ff == DFW'(DIR_FILT_CYC)) begin
                    dischgDir_ff <= isDsg; // RULE_04 RULE_05
                end
                if (chgFilt_ff == DFW'(DIR_FILT_CYC)) begin
                    chgDir_ff <= isChg; // RULE_04
                end
            end
        end
    end

    // Checks
    monitor_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_01
        !monitorOn |=> !dischgDir_ff && !chgDir_ff && dlyCnt_ff[DET_DOC] == 10'h000)
        else $error("direction or timer active while monitor off");

    dir_filter_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_04
        $rose(dischgDir_ff) |-> $past(isDsg) && $past(dsgFilt_ff) == DFW'(DIR_FILT_CYC))
        else $error("discharge direction set before filter time");

    dir_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_05
        $fell(dischgDir_ff) && $past(monitorOn) |-> !$past(isDsg) && $past(dsgFilt_ff) == DFW'(DIR_FILT_CYC))
        else $error("discharge direction cleared early");

    gain_follow_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_06
        cfg_ff[1:0] == 2'b01 |=> measGain_ff == PCM_GAIN_X50)
        else $error("measurement gain not following select");

    result_store_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_08
        adcValid && monitorOn |=> result_ff == 14'($past(adcRaw) - $past(nvCalOffset)))
        else $error("corrected result not stored");

    auto_gain_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_10
        absSense >= AUTO_X5_LEVEL |=> ocGain_ff == PCM_GAIN_X5)
        else $error("overcurrent gain not coarse for large signal");

    doc_trip_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_14
        $rose(dischgOcFlag_ff) |-> $past(exceed[DET_DOC]) && $past(dlyCnt_ff[DET_DOC]) >= $past(dly_ff[DET_DOC][9:0]))
        else $error("discharge overcurrent declared before delay");

    timer_restart_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_17
        !exceed[DET_COC] |=> dlyCnt_ff[DET_COC] == 10'h000)
        else $error("delay timer kept count after drop");

    load_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_18
        $rose(dischgOcFlag_ff) |-> loadPresent_ff)
        else $error("load flag missing on discharge overcurrent");

    chgr_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_19
        $rose(chgOcFlag_ff) |-> chargerPresent_ff)
        else $error("charger flag missing on charge overcurrent");

    host_fet_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_20
        hostFetCtl && !shortFlag_ff |=> fetsOn_ff)
        else $error("FETs turned off while host owns them");

    short_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_21
        shortFlag_ff |=> !fetsOn_ff)
        else $error("FETs on during short-circuit");

    coc_trip_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_14
        $rose(chgOcFlag_ff) |-> $past(exceed[DET_COC]) && $past(dlyCnt_ff[DET_COC]) >= $past(dly_ff[DET_COC][9:0]))
        else $error("charge overcurrent declared before delay");

    sc_trip_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_14
        $rose(shortFlag_ff) |-> $past(exceed[DET_SC]) && $past(dlyCnt_ff[DET_SC]) >= $past(dly_ff[DET_SC][9:0]))
        else $error("short-circuit declared before delay");

    doc_level_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_11
        monitorOn && ocSense > 17'sh0_0300 |-> exceed[DET_DOC])
        else $error("discharge limit above top code");

    coc_level_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_12
        monitorOn && ocSense < -17'sh0_00C0 |-> exceed[DET_COC])
        else $error("charge limit above top code");

    sc_level_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_13
        monitorOn && ocSense > 17'sh0_0800 |-> exceed[DET_SC])
        else $error("short limit above top code");

    dir_excl_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_03
        !(chgDir_ff && dischgDir_ff))
        else $error("both direction flags set");

    us_count_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_16
        dly_ff[DET_DOC][11:10] == 2'b00 && exceed[DET_DOC] && usTick && dlyCnt_ff[DET_DOC] != 10'h3FF
        |=> dlyCnt_ff[DET_DOC] == $past(dlyCnt_ff[DET_DOC]) + 10'h001)
        else $error("microsecond timer missed a tick");

endmodule : pcm_current_monitor

// ==== core/pcm_pkg.sv ====
// Constants shared by the pack current monitor: register map, field layout,
// reset values, threshold tables and timing counts.
// Assumes a 40 MHz system clock and sense samples in eighths of a millivolt.
//
// Function
// RULE_01 - Monitor runs in every mode except sleep and power-down.
// RULE_02 - Sense voltage compared to short-circuit, discharge and charge overcurrent limits.
// RULE_03 - Low-level direction detect sets separate charge and discharge flags.
// RULE_04 - Direction flag sets only after uninterrupted current longer than 2ms.
// RULE_05 - Discharge flag clears after 2ms of charge or zero current.
// RULE_06 - Two-bit gain select picks x5, x50 or x500 for measurement.
// RULE_07 - Readout spans 250mV, 25mV, 2.5mV at the three gains.
// RULE_08 - Each conversion stores a 14-bit corrected result and 12-bit compare value.
// RULE_09 - Offset correction comes from the nonvolatile factory calibration value.
// RULE_10 - Overcurrent path controls its own gain, independent of measurement gain.
// RULE_11 - Discharge overcurrent codes map to 4,8,16,24,32,48,64,96 mV.
// RULE_12 - Charge overcurrent codes map to 1,2,4,6,8,12,16,24 mV.
// RULE_13 - Short-circuit codes map to 16,24,32,48,64,96,128,256 mV.
// RULE_14 - A fault is declared only after its own delay of continuous exceedance.
// RULE_15 - Each delay is 10-bit count plus 2-bit scale.
// RULE_16 - Scale 00 us, 01 ms, 10 s, 11 minutes, count up to 1024.
// RULE_17 - Delay counter restarts whenever the exceedance drops early.
// RULE_18 - Discharge overcurrent sets its flag and the load-present flag.
// RULE_19 - Charge overcurrent sets its flag and the charger-present flag.
// RULE_20 - Overcurrent turns FETs off only when host FET control is 0.
// RULE_21 - Short-circuit sets its flag and turns FETs off regardless.
package pcm_pkg;

    // Register byte addresses
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_DLY_DOC = 8'h04;
    localparam logic [7:0] REG_DLY_COC = 8'h08;
    localparam logic [7:0] REG_DLY_SC = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_CURRENT = 8'h14;

    // Configuration field positions
    localparam int CFG_GAIN_LSB = 0;
    localparam int CFG_DOC_LSB = 2;
    localparam int CFG_COC_LSB = 5;
    localparam int CFG_SC_LSB = 8;
    localparam int CFG_HOSTFET_BIT = 11;
    localparam int DLY_SCALE_LSB = 10;
    localparam int CUR_CMP_LSB = 16;

    // Status bit positions
    localparam int ST_DOC = 0;
    localparam int ST_COC = 1;
    localparam int ST_SC = 2;
    localparam int ST_LOAD = 3;
    localparam int ST_CHGR = 4;
    localparam int ST_DIR_CHG = 5;
    localparam int ST_DIR_DSG = 6;
    localparam int ST_FETS_ON = 7;
    localparam int ST_MON_ON = 8;

    // Reset values
    localparam logic [11:0] CFG_RESET = 12'h0_000;
    localparam logic [11:0] DLY_DOC_RESET = 12'h0_40A;
    localparam logic [11:0] DLY_COC_RESET = 12'h0_40A;
    localparam logic [11:0] DLY_SC_RESET = 12'h0_0C8;

    // Detector indices
    localparam int DET_DOC = 0;
    localparam int DET_COC = 1;
    localparam int DET_SC = 2;

    typedef enum logic [1:0] {
        PCM_GAIN_X5 = 2'b00,
        PCM_GAIN_X50 = 2'b01,
        PCM_GAIN_X500 = 2'b10
    } pcm_gain_t;

    typedef enum logic [2:0] {
        PCM_MODE_NORMAL = 3'b000,
        PCM_MODE_IDLE = 3'b001,
        PCM_MODE_DOZE = 3'b011,
        PCM_MODE_SLEEP = 3'b010,
        PCM_MODE_POWERDOWN = 3'b110
    } pcm_mode_t;

    // Sense samples are signed eighths of a millivolt, positive = discharge
    localparam int SENSE_LSB_PER_MV = 8;
    localparam logic signed [16:0] DIR_DET_LEVEL = 17'sh0_0002;
    localparam logic signed [16:0] AUTO_X50_LEVEL = 17'sh0_0014;
    localparam logic signed [16:0] AUTO_X5_LEVEL = 17'sh0_00C8;

    // Thresholds in mV, indexed by the 3-bit select code
    localparam logic [8:0] DOC_THR_MV [8] = '{9'h0_04, 9'h0_08, 9'h0_10, 9'h0_18,
                                              9'h0_20, 9'h0_30, 9'h0_40, 9'h0_60};
    localparam logic [8:0] COC_THR_MV [8] = '{9'h0_01, 9'h0_02, 9'h0_04, 9'h0_06,
                                              9'h0_08, 9'h0_0C, 9'h0_10, 9'h0_18};
    localparam logic [8:0] SC_THR_MV [8] = '{9'h0_10, 9'h0_18, 9'h0_20, 9'h0_30,
                                             9'h0_40, 9'h0_60, 9'h0_80, 9'h1_00};

    // Timing
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int US_TICK_CYCLES = CLK_FREQ_HZ / 1_000_000;
    localparam int US_PER_MS = 1000;
    localparam int MS_PER_S = 1000;
    localparam int S_PER_MIN = 60;
    localparam int DIR_FILT_TIME_MS = 2;
    localparam int DIR_FILT_CYCLES = DIR_FILT_TIME_MS * (CLK_FREQ_HZ / 1000);

endpackage : pcm_pkg
